// ### verilog/tum_cfg.svh
`ifndef TUM_CFG_SVH
`define TUM_CFG_SVH

// register byte offsets
`define TUM_OFF_CTRL 8'h00
`define TUM_OFF_SRC 8'h04
`define TUM_OFF_DST 8'h08
`define TUM_OFF_STAT 8'h0C

// control word field positions
`define TUM_SRC_MODE_LSB 0
`define TUM_DST_MODE_LSB 2
`define TUM_FLAG_COND_LSB 4
`define TUM_CTRL_USED_W 16

// port word field positions
`define TUM_LO_LSB 0
`define TUM_HI_LSB 16

// status word field positions
`define TUM_STAT_HIT_BIT 0
`define TUM_STAT_SEEN_BIT 1
`define TUM_STAT_CNT_LSB 16

// tcp flag bit positions in the flag vector
`define TUM_FIN_BIT 0
`define TUM_SYN_BIT 1
`define TUM_RST_BIT 2
`define TUM_PSH_BIT 3
`define TUM_ACK_BIT 4
`define TUM_URG_BIT 5

// reset values: ports don't-care, every flag don't-care, full range
`define TUM_CTRL_RST 16'hAAA0
`define TUM_PORT_RST 32'hFFFF0000

`endif

// ### verilog/tum_pkg.sv
package tum_pkg;

  // port condition modes
  typedef enum logic [1:0] {
    TUM_PM_ANY = 2'h0,
    TUM_PM_EXACT = 2'h1,
    TUM_PM_RANGE = 2'h2,
    TUM_PM_RSVD = 2'h3
  } tum_port_mode_t;

  // per-flag condition settings
  typedef enum logic [1:0] {
    TUM_FC_CLEAR = 2'h0,
    TUM_FC_SET = 2'h1,
    TUM_FC_ANY = 2'h2,
    TUM_FC_ANY2 = 2'h3
  } tum_flag_cond_t;

  // number of tcp control flags checked
  typedef logic [5:0] tum_flags_t;

endpackage

// ### verilog/tum_port_if.sv
`timescale 1ns/100ps
interface tum_port_if;
  import tum_pkg::*;
  // one port condition plus the frame's port value
  tum_port_mode_t mode;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] port;
  logic l4;
  logic ok;

  modport cfg (output mode, lo, hi, port, l4, input ok);
  modport cmp (input mode, lo, hi, port, l4, output ok);
endinterface

// ### verilog/tum_port_cmp.sv
`timescale 1ns/100ps
module tum_port_cmp (
  // condition and frame port in, verdict out
  tum_port_if.cmp pif
);
  import tum_pkg::*;

  // verdict of one port condition
  always_comb begin
    case (pif.mode)
      // don't-care ignores the port entirely
      TUM_PM_ANY: pif.ok = 1'b1;
      // only a tcp/udp frame with the same port
      TUM_PM_EXACT: pif.ok = pif.l4 && (pif.port == pif.lo);
      // inclusive bounds; lo above hi never matches
      TUM_PM_RANGE: begin
        pif.ok = pif.l4 && (pif.port >= pif.lo) &&
                 (pif.port <= pif.hi);
      end
      // reserved code behaves as don't-care
      default: pif.ok = 1'b1;
    endcase
  end
endmodule

// ### verilog/tum_entry_matcher.sv
`timescale 1ns/100ps
`include "tum_cfg.svh"

// Functional notes
// - source don't-care ignores source port
// - source exact mode needs equal port
// - source range mode needs port in bounds
// - destination don't-care ignores destination port
// - destination exact mode needs equal port
// - destination range mode needs port in bounds
// - fin condition: clear, set or any
// - syn condition: clear, set or any
// - rst condition: clear, set or any
// - psh condition: clear, set or any
// - ack condition: clear, set or any
// - urg condition: clear, set or any
module tum_entry_matcher #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // parsed frame header, one frame per valid cycle
  input wire logic frm_valid,
  input wire logic frm_is_tcp,
  input wire logic frm_is_udp,
  input wire logic [15:0] frm_src_port,
  input wire logic [15:0] frm_dst_port,
  input wire tum_pkg::tum_flags_t frm_tcp_flags,
  // match verdict, one cycle after the frame
  output logic match_valid,
  output logic match_hit
);
  import tum_pkg::*;

  // flag check shared by all six flags
  function automatic logic flag_ok(input logic [1:0] cond,
                                   input logic tcp,
                                   input logic flag);
    logic seen;
    seen = tcp && flag;
    case (cond)
      // a set flag blocks; udp carries no flags so passes
      TUM_FC_CLEAR: flag_ok = !seen;
      // only a tcp frame with the flag set passes
      TUM_FC_SET: flag_ok = seen;
      // don't-care
      default: flag_ok = 1'b1;
    endcase
  endfunction

  // decode of a word offset within the map
  function automatic logic hit_off(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
    hit_off = (a == ADDR_W'(off));
  endfunction

  // entry settings
  logic [15:0] ctrl_q; // modes and flag conditions
  logic [31:0] src_q; // source lo/exact and hi
  logic [31:0] dst_q; // destination lo/exact and hi
  // block state seen by software
  logic last_hit_q; // verdict of the latest frame
  logic seen_q; // any frame judged since reset
  logic [15:0] hit_cnt_q; // hits, wraps at 16 bits
  // bus outputs
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  // verdict outputs
  logic match_valid_q;
  logic match_hit_q;

  // bus phase decode
  logic setup_ph; // first cycle of a transfer
  logic wr_done; // write completes this edge
  logic mapped; // address names a register
  logic [31:0] rd_mux; // read value before register

  // condition fields
  logic [1:0] src_mode;
  logic [1:0] dst_mode;
  logic [11:0] fcond;
  logic l4;

  // per-condition verdicts
  logic src_ok;
  logic dst_ok;
  tum_flags_t flg_ok;
  logic all_ok;

  tum_port_if src_if ();
  tum_port_if dst_if ();

  assign src_mode = ctrl_q[`TUM_SRC_MODE_LSB +: 2];
  assign dst_mode = ctrl_q[`TUM_DST_MODE_LSB +: 2];
  assign fcond = ctrl_q[`TUM_FLAG_COND_LSB +: 12];
  assign l4 = frm_is_tcp || frm_is_udp;

  // feed the two port comparators
  assign src_if.mode = tum_port_mode_t'(src_mode);
  assign src_if.lo = src_q[`TUM_LO_LSB +: 16];
  assign src_if.hi = src_q[`TUM_HI_LSB +: 16];
  assign src_if.port = frm_src_port;
  assign src_if.l4 = l4;
  assign dst_if.mode = tum_port_mode_t'(dst_mode);
  assign dst_if.lo = dst_q[`TUM_LO_LSB +: 16];
  assign dst_if.hi = dst_q[`TUM_HI_LSB +: 16];
  assign dst_if.port = frm_dst_port;
  assign dst_if.l4 = l4;

  // source port condition
  tum_port_cmp u_src_cmp (
    .pif (src_if.cmp)
  );

  // destination port condition
  tum_port_cmp u_dst_cmp (
    .pif (dst_if.cmp)
  );

  assign src_ok = src_if.ok;
  assign dst_ok = dst_if.ok;

  // flag conditions, two bits each in flag bit order
  always_comb begin
    flg_ok[`TUM_FIN_BIT] = flag_ok(fcond[1:0], frm_is_tcp,
      frm_tcp_flags[`TUM_FIN_BIT]);
    flg_ok[`TUM_SYN_BIT] = flag_ok(fcond[3:2], frm_is_tcp,
      frm_tcp_flags[`TUM_SYN_BIT]);
    flg_ok[`TUM_RST_BIT] = flag_ok(fcond[5:4], frm_is_tcp,
      frm_tcp_flags[`TUM_RST_BIT]);
    flg_ok[`TUM_PSH_BIT] = flag_ok(fcond[7:6], frm_is_tcp,
      frm_tcp_flags[`TUM_PSH_BIT]);
    flg_ok[`TUM_ACK_BIT] = flag_ok(fcond[9:8], frm_is_tcp,
      frm_tcp_flags[`TUM_ACK_BIT]);
    flg_ok[`TUM_URG_BIT] = flag_ok(fcond[11:10], frm_is_tcp,
      frm_tcp_flags[`TUM_URG_BIT]);
  end

  // every active condition at once
  assign all_ok = src_ok && dst_ok && (&flg_ok);

  // verdict register, one cycle after the frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      match_valid_q <= 1'b0;
      match_hit_q <= 1'b0;
    end else begin
      match_valid_q <= frm_valid;
      // hit only qualified by a real frame
      match_hit_q <= frm_valid && all_ok;
    end
  end

  // software view of recent verdicts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_hit_q <= 1'b0;
      seen_q <= 1'b0;
      hit_cnt_q <= 16'h0000;
    end else if (frm_valid) begin
      last_hit_q <= all_ok;
      seen_q <= 1'b1;
      // counter wraps; software takes differences
      if (all_ok) begin
        hit_cnt_q <= hit_cnt_q + 16'h0001;
      end
    end
  end

  // apb phase decode
  assign setup_ph = psel && !penable;
  assign wr_done = psel && penable && pready_q && pwrite;
  assign mapped = hit_off(paddr, `TUM_OFF_CTRL) ||
                  hit_off(paddr, `TUM_OFF_SRC) ||
                  hit_off(paddr, `TUM_OFF_DST) ||
                  hit_off(paddr, `TUM_OFF_STAT);

  // read mux; reserved bits read zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_off(paddr, `TUM_OFF_CTRL)) begin
      rd_mux[`TUM_CTRL_USED_W-1:0] = ctrl_q;
    end else if (hit_off(paddr, `TUM_OFF_SRC)) begin
      rd_mux = src_q;
    end else if (hit_off(paddr, `TUM_OFF_DST)) begin
      rd_mux = dst_q;
    end else if (hit_off(paddr, `TUM_OFF_STAT)) begin
      rd_mux[`TUM_STAT_HIT_BIT] = last_hit_q;
      rd_mux[`TUM_STAT_SEEN_BIT] = seen_q;
      rd_mux[`TUM_STAT_CNT_LSB +: 16] = hit_cnt_q;
    end
  end

  // fixed zero-wait answer: ready in the first access cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup_ph;
      if (setup_ph) begin
        // unmapped offsets answer with an error, data zero
        pslverr_q <= !mapped;
        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
      end else if (!psel) begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h00000000;
      end
    end
  end

  // entry settings; a change applies to the next frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `TUM_CTRL_RST;
      src_q <= `TUM_PORT_RST;
      dst_q <= `TUM_PORT_RST;
    end else if (wr_done) begin
      // status is read only; writes there are dropped
      if (hit_off(paddr, `TUM_OFF_CTRL)) begin
        ctrl_q <= pwdata[`TUM_CTRL_USED_W-1:0];
      end
      if (hit_off(paddr, `TUM_OFF_SRC)) begin
        src_q <= pwdata;
      end
      if (hit_off(paddr, `TUM_OFF_DST)) begin
        dst_q <= pwdata;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign match_valid = match_valid_q;
  assign match_hit = match_hit_q;

  // checks on the verdict against the settings in force, and on the apb answer
  src_any_a: assert property (@(posedge clk) disable iff (!rst_n)
    frm_valid && src_mode == TUM_PM_ANY && dst_mode == TUM_PM_ANY &&
    (&flg_ok) |=> match_hit_q)
    else $error("source don't-care still blocked a frame");

  src_exact_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && src_mode == TUM_PM_EXACT &&
    frm_src_port != src_q[15:0] |=> !match_hit_q)
    else $error("exact source mismatch gave a hit");

  src_range_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && src_mode == TUM_PM_RANGE && l4 &&
    (frm_src_port < src_q[15:0] || frm_src_port > src_q[31:16])
    |=> !match_hit_q)
    else $error("source outside range gave a hit");

  dst_any_a: assert property (@(posedge clk) disable iff (!rst_n)
    frm_valid && dst_mode == TUM_PM_ANY |-> dst_ok)
    else $error("destination don't-care rejected a frame");

  dst_exact_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && dst_mode == TUM_PM_EXACT && l4 &&
    frm_dst_port == dst_q[15:0] && src_ok && (&flg_ok)
    |=> match_valid_q && match_hit_q)
    else $error("exact destination equal port missed");

  dst_range_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && dst_mode == TUM_PM_RANGE &&
    (frm_dst_port < dst_q[15:0] || frm_dst_port > dst_q[31:16])
    |=> !match_hit_q)
    else $error("destination outside range gave a hit");

  fin_set_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && fcond[1:0] == TUM_FC_SET &&
    !(frm_is_tcp && frm_tcp_flags[`TUM_FIN_BIT]) |=> !match_hit_q)
    else $error("fin must-be-set passed without fin");

  syn_clear_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && fcond[3:2] == TUM_FC_CLEAR && frm_is_tcp &&
    frm_tcp_flags[`TUM_SYN_BIT] |=> !match_hit_q)
    else $error("syn must-be-clear passed a syn frame");

  rst_flag_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && fcond[5:4] == TUM_FC_CLEAR && frm_is_tcp &&
    frm_tcp_flags[`TUM_RST_BIT] |=> !match_hit_q)
    else $error("rst must-be-clear passed an rst frame");

  psh_flag_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && fcond[7:6] == TUM_FC_SET && !frm_is_tcp
    |=> !match_hit_q)
    else $error("psh must-be-set passed a non-tcp frame");

  ack_any_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    fcond[9:8] >= TUM_FC_ANY |-> flg_ok[`TUM_ACK_BIT])
    else $error("ack don't-care rejected a frame");

  urg_set_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && fcond[11:10] == TUM_FC_SET &&
    !frm_tcp_flags[`TUM_URG_BIT] |=> !match_hit_q)
    else $error("urg must-be-set passed without urg");

  hit_and_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    match_hit_q |-> $past(frm_valid) && $past(src_ok) &&
    $past(dst_ok) && $past(&flg_ok))
    else $error("hit without every condition met");

  apb_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    psel && !penable ##1 psel && penable |-> pready_q)
    else $error("access phase did not answer in one cycle");

  fin_clear_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && fcond[1:0] == TUM_FC_CLEAR && frm_is_tcp &&
    frm_tcp_flags[`TUM_FIN_BIT] |=> !match_hit_q)
    else $error("fin must-be-clear passed a fin frame");

  ack_set_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && fcond[9:8] == TUM_FC_SET &&
    !(frm_is_tcp && frm_tcp_flags[`TUM_ACK_BIT]) |=> !match_hit_q)
    else $error("ack must-be-set passed without ack");

  urg_clear_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid && fcond[11:10] == TUM_FC_CLEAR && frm_is_tcp &&
    frm_tcp_flags[`TUM_URG_BIT] |=> !match_hit_q)
    else $error("urg must-be-clear passed an urg frame");

  verdict_lat_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    frm_valid |=> match_valid_q)
    else $error("frame gave no verdict one cycle later");

  apb_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    setup_ph && !mapped |=> pready_q && pslverr_q)
    else $error("unmapped access answered without error");

endmodule

// ### sim/tum_frame_src.sv
`timescale 1ns/100ps
// receive pipeline stand-in: one parsed header per send call
module tum_frame_src (
  // clock
  input wire logic clk,
  // parsed header out
  output logic frm_valid,
  output logic frm_is_tcp,
  output logic frm_is_udp,
  output logic [15:0] frm_src_port,
  output logic [15:0] frm_dst_port,
  output tum_pkg::tum_flags_t frm_tcp_flags
);
  import tum_pkg::*;
  initial begin
    frm_valid = 1'b0;
    {frm_is_tcp, frm_is_udp, frm_src_port, frm_dst_port} = '0;
    frm_tcp_flags = '0;
  end
  // one header, held until the next send or idle call
  task automatic send(input logic [1:0] t, input logic [15:0] sp,
                      input logic [15:0] dp, input logic [5:0] fl);
    @(posedge clk);
    frm_valid <= 1'b1;
    frm_is_tcp <= (t == 2'h0);
    frm_is_udp <= (t == 2'h1);
    frm_src_port <= sp;
    frm_dst_port <= dp;
    frm_tcp_flags <= fl;
  endtask
  // gap: stale fields except frm_is_udp are inverted so nothing leans on them
  task automatic idle();
    @(posedge clk);
    frm_valid <= 1'b0;
    frm_src_port <= ~frm_src_port;
    frm_dst_port <= ~frm_dst_port;
    frm_tcp_flags <= ~frm_tcp_flags;
    frm_is_tcp <= ~frm_is_tcp;
  endtask
endmodule

// ### sim/tb_tcp_udp_entry_matcher.sv
`timescale 1ns/100ps
`include "tum_cfg.svh"
module tb_tcp_udp_entry_matcher;
  import tum_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, srcw, dstw;
  logic fv, ft, fu, match_valid, match_hit, last;
  logic [15:0] fs, fd, ctrl, sp, dp, hits;
  tum_flags_t ff, fl;
  logic [1:0] t;
  logic q[$]; // expected verdicts, oldest first
  int err_count, checks_done;

  tum_entry_matcher uut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frm_valid(fv),
    .frm_is_tcp(ft), .frm_is_udp(fu), .frm_src_port(fs),
    .frm_dst_port(fd), .frm_tcp_flags(ff), .match_valid(match_valid),
    .match_hit(match_hit));
  tum_frame_src src (.clk(clk), .frm_valid(fv), .frm_is_tcp(ft),
    .frm_is_udp(fu), .frm_src_port(fs), .frm_dst_port(fd),
    .frm_tcp_flags(ff));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // single-bit results: error flag and frame verdict
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [32:0] r);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    cmp(r[31:0], e[31:0]);
    cmp_bit(r[32], e[32]);
  endtask

  // bench's own reading of one port condition
  function automatic logic pok(logic [1:0] m, logic [31:0] w,
                               logic [15:0] p, logic l4);
    if (m == 2'h1) return l4 && p == w[15:0];
    if (m == 2'h2) return l4 && p >= w[15:0] && p <= w[31:16];
    return 1'b1;
  endfunction
  function automatic logic hit_of();
    logic h;
    h = pok(ctrl[1:0], srcw, sp, t < 2'h2) && pok(ctrl[3:2], dstw, dp,
        t < 2'h2);
    for (int i = 0; i < 6; i++) begin
      if (ctrl[4+2*i+:2] == 2'h0 && t == 2'h0 && fl[i]) h = 1'b0;
      if (ctrl[4+2*i+:2] == 2'h1 && !(t == 2'h0 && fl[i])) h = 1'b0;
    end
    return h;
  endfunction
  // ports near the bounds catch off-by-one compares
  function automatic logic [15:0] pick(logic [31:0] w);
    case ($urandom % 5)
      0: return w[15:0];
      1: return w[31:16];
      2: return w[15:0] - 16'h1;
      3: return w[31:16] + 16'h1;
      default: return 16'($urandom);
    endcase
  endfunction

  // verdict watcher
  always @(posedge clk) begin
    if (rst_n && match_valid === 1'b1) begin
      if (q.size() == 0) cmp_bit(1'b1, 1'b0);
      else cmp_bit(match_hit, q.pop_front());
    end
  end

  task automatic conclude();
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {err_count, checks_done, hits, last} = '0;
    void'($urandom(32'h79dc590f));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`TUM_OFF_CTRL, 33'h0_0000AAA0);
    rd(`TUM_OFF_SRC, 33'h0_FFFF0000);
    rd(`TUM_OFF_DST, 33'h0_FFFF0000);
    rd(8'h10, 33'h1_00000000);
    wr(`TUM_OFF_STAT, 32'hFFFFFFFF);
    rd(`TUM_OFF_STAT, 33'h0);
    // every source and destination mode pair
    for (int c = 0; c < 16; c++) begin
      ctrl = {12'($urandom | $urandom), 2'(c / 4), 2'(c)};
      srcw = $urandom;
      dstw = $urandom;
      // range modes get hi set 0 to 63 above lo so both bounds can match
      if (c[1]) srcw[31:16] = srcw[15:0] + 16'($urandom % 64);
      if (c[3]) dstw[31:16] = dstw[15:0] + 16'($urandom % 64);
      wr(`TUM_OFF_CTRL, {16'hFFFF, ctrl});
      wr(`TUM_OFF_SRC, srcw);
      wr(`TUM_OFF_DST, dstw);
      rd(`TUM_OFF_CTRL, {17'h0, ctrl});
      for (int k = 0; k < 16; k++) begin
        t = 2'($urandom % 3);
        sp = pick(srcw);
        dp = pick(dstw);
        fl = 6'($urandom);
        last = hit_of();
        hits += 16'(last);
        q.push_back(last);
        src.send(t, sp, dp, fl);
        if ($urandom % 3 == 0) src.idle();
      end
      src.idle();
      repeat (2) @(posedge clk);
      rd(`TUM_OFF_STAT, {1'b0, hits, 14'h0, 1'b1, last});
    end
    conclude();
  end
endmodule
